// ### bench/atc_timer_regs_bench.sv
/*
 * Self-checking bench for the timer register block, with a register model.
 * Assumes the block's hand-over timing: one access per strobe, read data
 * one cycle after the read edge, busy transfers closed by an oscillator rise.
 */
`timescale 1ns/1ps
`define ATC_CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("MISMATCH time=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module atc_timer_regs_bench;
    // ****************************************************************
    // Signals, model state and the design instance.
    // ****************************************************************
    logic       i_clk = 1'b0;
    logic       i_rst_b = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic       i_io_space = 1'b0;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic [7:0] i_wdata = 8'h00;
    logic       i_global_ie = 1'b0;
    logic [2:0] i_irq_ack = 3'h0;
    logic       i_timer_osc_pin = 1'b0;
    logic [7:0] o_rdata;
    logic [2:0] o_irq_req;
    logic       o_wave_out_a;
    logic       o_wave_out_b;
    logic       o_xtal_osc_en;
    logic       o_ext_clock_buf_en;
    logic       o_shared_prescale_rst;
    int         mismatches = 0;
    int         total_checks = 0;
    logic [31:0] seed = 32'h14C59F3D;
    logic [7:0]  mdl [256];
    logic [7:0]  busy = 8'h00;
    logic [7:0]  pend_a [$];
    logic [7:0]  pend_d [$];
    logic [7:0]  v;
    logic [7:0]  psc_seq [5] = '{8'h81, 8'h82, 8'h00, 8'h01, 8'h02};
    atc_timer_regs atc_timer_regs_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_io_space(i_io_space),
        .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .i_global_ie(i_global_ie), .i_irq_ack(i_irq_ack),
        .i_timer_osc_pin(i_timer_osc_pin), .o_rdata(o_rdata), .o_irq_req(o_irq_req), .o_wave_out_a(o_wave_out_a),
        .o_wave_out_b(o_wave_out_b), .o_xtal_osc_en(o_xtal_osc_en), .o_ext_clock_buf_en(o_ext_clock_buf_en),
        .o_shared_prescale_rst(o_shared_prescale_rst));
    // Free-running 100 MHz clock.
    always #5 i_clk = ~i_clk;
    // ****************************************************************
    // Helpers: random source, bus cycles and the closing task.
    // ****************************************************************
    // Xorshift source, so every run sees the same values.
    function automatic logic [7:0] rnd8();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd8
    // One write strobe, then the model takes the same write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io);
        logic [7:0] da;
        int         bi;
        da = io ? a + atc_pkg::IO_OFFSET : a;
        bi = -1;
        @(posedge i_clk);
        i_addr <= a;
        i_io_space <= io;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        for (int i = 0; i < atc_pkg::N_ASYNC; i++)
            if (atc_pkg::ASYNC_ADDR[i] == da) bi = i;
        if (da == atc_pkg::A_IRQ_FLAGS) mdl[da] = mdl[da] & ~d;
        else if (da == atc_pkg::A_SYNC_PSC) mdl[da] = d[7] ? (d & 8'h83) : 8'h00;
        else if (da == atc_pkg::A_ASYNC_ST) mdl[da] = d & 8'h60;
        else if (bi >= 0 && mdl[atc_pkg::A_ASYNC_ST][5])
        begin
            pend_a.push_back(da);
            pend_d.push_back(d);
            busy[bi] = 1'b1;
        end
        else if (da == atc_pkg::A_IRQ_EN) mdl[da] = d & 8'h07;
        else if (da == atc_pkg::A_CTL_B) mdl[da] = d & 8'h0F;
        else if (bi >= 0) mdl[da] = d;
    endtask : wr
    // One read strobe; the answer is compared once it has settled.
    task automatic chkrd(input logic [7:0] a, input logic io, input logic [7:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_io_space <= io;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        #1;
        `ATC_CHK(o_rdata, exp)
    endtask : chkrd
    // Lets a few edges pass so registered outputs have landed.
    task automatic settle();
        repeat (4) @(posedge i_clk);
        #1;
    endtask : settle
    // Prints the counts and the verdict, then stops the run.
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    // Watchdog sized well above the few hundred cycles the tests need.
    initial
    begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        wrap_up();
    end
    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial
    begin
        foreach (mdl[i]) mdl[i] = 8'h00;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        // Reset values, then an unmapped write that must be ignored.
        for (int i = 0; i < atc_pkg::N_ASYNC; i++) chkrd(atc_pkg::ASYNC_ADDR[i], 1'b0, 8'h00);
        `ATC_CHK(o_xtal_osc_en, 1'b1)
        wr(8'hA0, rnd8(), 1'b0);
        chkrd(8'hA0, 1'b0, 8'h00);
        // Compare values read back as written, enables as their low three bits.
        wr(atc_pkg::A_CMP_A, rnd8(), 1'b0);
        wr(atc_pkg::A_CMP_B, rnd8(), 1'b0);
        wr(atc_pkg::A_IRQ_EN, rnd8(), 1'b0);
        chkrd(atc_pkg::A_CMP_A, 1'b0, mdl[atc_pkg::A_CMP_A]);
        chkrd(atc_pkg::A_CMP_B, 1'b0, mdl[atc_pkg::A_CMP_B]);
        chkrd(atc_pkg::A_IRQ_EN, 1'b0, mdl[atc_pkg::A_IRQ_EN]);
        // Run the counter undivided past a full wrap, then stop it.
        wr(atc_pkg::A_IRQ_EN, 8'h07, 1'b0);
        i_global_ie <= 1'b1;
        wr(atc_pkg::A_CTL_B, 8'h01, 1'b0);
        repeat (300) @(posedge i_clk);
        wr(atc_pkg::A_CTL_B, 8'h00, 1'b0);
        mdl[atc_pkg::A_IRQ_FLAGS] = 8'h07;
        chkrd(8'h17, 1'b1, mdl[atc_pkg::A_IRQ_FLAGS]);
        `ATC_CHK(o_irq_req, 3'h7)
        @(posedge i_clk) i_global_ie <= 1'b0;
        settle();
        `ATC_CHK(o_irq_req, 3'h0)
        @(posedge i_clk) i_global_ie <= 1'b1;
        // Clearing by writing ones, zero writes, and vector acknowledge.
        wr(8'h17, 8'h02, 1'b1);
        chkrd(atc_pkg::A_IRQ_FLAGS, 1'b0, mdl[atc_pkg::A_IRQ_FLAGS]);
        wr(atc_pkg::A_IRQ_FLAGS, 8'h00, 1'b0);
        chkrd(atc_pkg::A_IRQ_FLAGS, 1'b0, mdl[atc_pkg::A_IRQ_FLAGS]);
        @(posedge i_clk);
        i_irq_ack <= 3'h4;
        @(posedge i_clk);
        i_irq_ack <= 3'h0;
        mdl[atc_pkg::A_IRQ_FLAGS] = mdl[atc_pkg::A_IRQ_FLAGS] & 8'hFB;
        chkrd(atc_pkg::A_IRQ_FLAGS, 1'b0, mdl[atc_pkg::A_IRQ_FLAGS]);
        `ATC_CHK(o_irq_req, mdl[atc_pkg::A_IRQ_FLAGS][2:0])
        // Count equal to both compares while stopped: the first tick after starting gives no match.
        wr(atc_pkg::A_COUNT, mdl[atc_pkg::A_CMP_A], 1'b0);
        wr(atc_pkg::A_CMP_B, mdl[atc_pkg::A_CMP_A], 1'b0);
        wr(atc_pkg::A_IRQ_FLAGS, 8'h07, 1'b0);
        v[1:0] = {o_wave_out_b, o_wave_out_a};
        wr(atc_pkg::A_CTL_B, 8'h01, 1'b0);
        wr(atc_pkg::A_CTL_B, 8'h00, 1'b0);
        settle();
        `ATC_CHK(o_irq_req[2:1], 2'h0)
        `ATC_CHK({o_wave_out_b, o_wave_out_a}, v[1:0])
        // Prescaler reset bits held under sync mode, self-clearing without it.
        foreach (psc_seq[i])
        begin
            wr(atc_pkg::A_SYNC_PSC, psc_seq[i], 1'b0);
            settle();
            `ATC_CHK(o_shared_prescale_rst, mdl[atc_pkg::A_SYNC_PSC][0])
            chkrd(atc_pkg::A_SYNC_PSC, 1'b0, mdl[atc_pkg::A_SYNC_PSC]);
        end
        // External clock first, then asynchronous select.
        wr(atc_pkg::A_ASYNC_ST, 8'h40, 1'b0);
        settle();
        `ATC_CHK(o_xtal_osc_en, 1'b0)
        `ATC_CHK(o_ext_clock_buf_en, 1'b0)
        wr(atc_pkg::A_ASYNC_ST, 8'h60, 1'b0);
        settle();
        `ATC_CHK(o_ext_clock_buf_en, 1'b1)
        // One write to each register, none while its busy bit is up.
        for (int i = 0; i < atc_pkg::N_ASYNC; i++)
            wr(atc_pkg::ASYNC_ADDR[i], (i <= atc_pkg::RI_CTL_A) ? 8'h00 : rnd8(), 1'b0);
        chkrd(atc_pkg::A_ASYNC_ST, 1'b0, mdl[atc_pkg::A_ASYNC_ST] | busy);
        chkrd(atc_pkg::A_CMP_A, 1'b0, mdl[atc_pkg::A_CMP_A]);
        // An oscillator rise commits every held value and drops busy.
        @(posedge i_clk);
        i_timer_osc_pin <= 1'b1;
        repeat (8) @(posedge i_clk);
        while (pend_a.size() > 0)
            mdl[pend_a.pop_front()] = pend_d.pop_front();
        busy = 8'h00;
        chkrd(atc_pkg::A_ASYNC_ST, 1'b0, mdl[atc_pkg::A_ASYNC_ST]);
        for (int i = atc_pkg::RI_CMP_B; i < atc_pkg::N_ASYNC; i++)
            chkrd(atc_pkg::ASYNC_ADDR[i], 1'b0, mdl[atc_pkg::ASYNC_ADDR[i]]);
        i_timer_osc_pin <= 1'b0;
        wrap_up();
    end
endmodule : atc_timer_regs_bench

// ### verilog/atc_pkg.sv
/*
 * Constants shared by the timer register block and its prescaler.
 * Assumes an 8-bit data-space address where I/O addresses are offset by 0x20.
 */
package atc_pkg;
    // Data-space offsets of the registers.
    localparam logic [7:0] A_IRQ_FLAGS = 8'h37;
    localparam logic [7:0] A_SYNC_PSC  = 8'h43;
    localparam logic [7:0] A_IRQ_EN    = 8'h70;
    localparam logic [7:0] A_CTL_A     = 8'hB0;
    localparam logic [7:0] A_CTL_B     = 8'hB1;
    localparam logic [7:0] A_COUNT     = 8'hB2;
    localparam logic [7:0] A_CMP_A     = 8'hB3;
    localparam logic [7:0] A_CMP_B     = 8'hB4;
    localparam logic [7:0] A_ASYNC_ST  = 8'hB6;
    localparam logic [7:0] IO_OFFSET   = 8'h20;
    // Index of each asynchronous register, equal to its busy bit position.
    localparam int RI_CTL_B = 0;
    localparam int RI_CTL_A = 1;
    localparam int RI_CMP_B = 2;
    localparam int RI_CMP_A = 3;
    localparam int RI_COUNT = 4;
    localparam int N_ASYNC  = 5;
    localparam logic [7:0] ASYNC_ADDR [5] = '{8'hB1, 8'hB0, 8'hB4, 8'hB3, 8'hB2};
    // Field positions.
    localparam int B_WRAP    = 0;
    localparam int B_MATCH_A = 1;
    localparam int B_MATCH_B = 2;
    localparam int B_EXT_CLK = 6;
    localparam int B_AS_SEL  = 5;
    localparam int B_TSM     = 7;
    localparam int B_PSR_ASY = 1;
    localparam int B_PSR_SYN = 0;
    // Counter limits and reset value.
    localparam logic [7:0] CNT_MAX    = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] RST_VAL    = 8'h00;
    localparam logic [1:0] WGM_PHASE  = 2'h1;
    // Divider masks per clock select: stop, 1, 8, 32, 64, 128, 256, 1024.
    localparam logic [9:0] DIV_MASK [8] = '{10'h000, 10'h000, 10'h007, 10'h01F,
                                            10'h03F, 10'h07F, 10'h0FF, 10'h3FF};
endpackage : atc_pkg

// ### verilog/atc_pre_if.sv
/*
 * Link between the register block and its prescaler.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface atc_pre_if;
    logic       tick_src;
    logic       clr;
    logic [2:0] sel;
    logic       tick_out;
    modport pre (input tick_src, input clr, input sel, output tick_out);
    modport ctl (output tick_src, output clr, output sel, input tick_out);
endinterface : atc_pre_if

// ### verilog/atc_prescaler.sv
/*
 * Prescaler: divides the timer clock enable by the selected ratio.
 * Assumes tick_src is a one-cycle enable and clr is a level.
 */
`timescale 1ns/1ps
module atc_prescaler #(
    parameter int DIV_W = 10
) (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    atc_pre_if.pre    p
);
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] mask;

    assign mask = atc_pkg::DIV_MASK[p.sel];

    // Free divider, held at zero while the reset bit is on.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            div_q <= '0;
        else if (p.clr)
            div_q <= '0;
        else if (p.tick_src)
            div_q <= div_q + 1'b1;
    end

    // Output tick when every masked divider bit is one; select zero stops.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            p.tick_out <= 1'b0;
        else
            p.tick_out <= p.tick_src && !p.clr && (p.sel != 3'h0)
                          && ((div_q & mask) == mask);
    end
endmodule : atc_prescaler

// ### verilog/atc_timer_regs.sv
/*
 * Register side of an 8-bit timer with asynchronous clock option.
 * Assumes a single-cycle CPU register port on i_clk (the I/O clock) and
 * an asynchronous oscillator level on i_timer_osc_pin.
 */
//Contract
//- Two 8-bit compare values compared with count; match flags and drives wave pin.
//- Interrupt requested only when enable bit, global bit and flag are one.
//- Compare A or B flag set when count equals that compare value.
//- Each flag clears when its interrupt vector is executed.
//- Writing one to a flag bit clears that flag.
//- Wrap flag set on overflow, or at bottom turnaround in PWM.
//- Flag register at data offset 0x37 or I/O address 0x17.
//- External clock input used when its bit set; crystal runs only when clear. Code enables the input buffer only when async select is also set.
//- Async select bit picks I/O clock (0) or oscillator pin (1).
//- Switching clock source may corrupt timer registers; software rewrites them.
//- Async count write sets busy bit 4 until value reaches counter.
//- Async compare and control writes set busy bits 3..0 until transferred.
//- Sync mode holds both prescaler resets; clearing it releases both.
//- Async prescaler reset self-clears, waits in async mode, holds in sync mode.
//- Shared prescaler reset self-clears unless sync mode is on.
//- Clock select: stop, 1, 8, 32, 64, 128, 256, 1024.
//- Count write blocks compare match on next timer tick.
`timescale 1ns/1ps
module atc_timer_regs (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] i_addr,
    input  wire logic       i_io_space,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_global_ie,
    input  wire logic [2:0] i_irq_ack,
    input  wire logic       i_timer_osc_pin,
    output logic      [7:0] o_rdata,
    output logic      [2:0] o_irq_req,
    output logic            o_wave_out_a,
    output logic            o_wave_out_b,
    output logic            o_xtal_osc_en,
    output logic            o_ext_clock_buf_en,
    output logic            o_shared_prescale_rst
);
    // ************************************************
    // Decode and oscillator sampling
    // ************************************************
    logic [7:0] addr;
    logic       wr_flags;
    logic       wr_psc;
    logic       wr_en;
    logic       wr_ast;
    logic [4:0] wr_hit;
    logic       osc_s1_q;
    logic       osc_s2_q;
    logic       osc_d3_q;
    logic       src_tick;
    logic       cnt_tick;
    logic [7:0] irq_en_q;
    logic       ext_clock_in_en_q;
    logic       async_clock_sel_q;
    logic       as_chg;
    logic       sync_hold_mode_q;
    logic       async_prescale_reset_q;
    logic       shared_prescale_reset_q;
    logic [4:0] busy_q;
    logic [7:0] hold_q [5];
    logic [4:0] commit;
    logic [7:0] commit_val [5];
    logic [7:0] work_q [4];
    logic [7:0] count_value_q;
    logic       down_q;
    logic       blk_q;
    logic       match_a;
    logic       match_b;
    logic       wrap;
    logic [2:0] flags_q;
    logic [2:0] flags_d;
    logic [2:0] flag_clr;
    logic       pwm;

    // I/O addressing is the data offset less 0x20.
    assign addr     = i_io_space ? 8'(i_addr + atc_pkg::IO_OFFSET) : i_addr;
    assign wr_flags = i_wr && (addr == atc_pkg::A_IRQ_FLAGS);
    assign wr_psc   = i_wr && (addr == atc_pkg::A_SYNC_PSC);
    assign wr_en    = i_wr && (addr == atc_pkg::A_IRQ_EN);
    assign wr_ast   = i_wr && (addr == atc_pkg::A_ASYNC_ST);
    assign as_chg   = wr_ast && (i_wdata[atc_pkg::B_AS_SEL] != async_clock_sel_q);

    // Pin level passes two flops before the edge detector sees it.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_d3_q <= 1'b0;
        end
        else
        begin
            osc_s1_q <= i_timer_osc_pin;
            osc_s2_q <= osc_s1_q;
            osc_d3_q <= osc_s2_q;
        end
    end

    // Timer clock enable: every I/O clock, or each oscillator rising edge.
    assign src_tick = async_clock_sel_q ? (osc_s2_q && !osc_d3_q) : 1'b1;

    // ************************************************
    // Prescaler
    // ************************************************
    atc_pre_if pre_if ();

    assign pre_if.tick_src = src_tick;
    assign pre_if.clr      = async_prescale_reset_q;
    assign pre_if.sel      = work_q[atc_pkg::RI_CTL_B][2:0];
    assign cnt_tick        = pre_if.tick_out;

    atc_prescaler #(.DIV_W(10)) u_pre (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .p       (pre_if.pre)
    );

    // ************************************************
    // Asynchronous holding registers
    // ************************************************
    generate
        for (genvar k = 0; k < atc_pkg::N_ASYNC; k++)
        begin : g_async
            assign wr_hit[k] = i_wr && (addr == atc_pkg::ASYNC_ADDR[k]);
            // Async writes land in a holding register and wait for a timer tick.
            always_ff @(posedge i_clk or negedge i_rst_b)
            begin
                if (!i_rst_b)
                begin
                    busy_q[k] <= 1'b0;
                    hold_q[k] <= atc_pkg::RST_VAL;
                end
                else if (as_chg)
                    busy_q[k] <= 1'b0;
                else if (wr_hit[k] && async_clock_sel_q)
                begin
                    busy_q[k] <= 1'b1;
                    hold_q[k] <= i_wdata;
                end
                else if (busy_q[k] && src_tick)
                    busy_q[k] <= 1'b0;
            end
            // Synchronous writes take effect at once.
            assign commit[k]     = async_clock_sel_q ? (busy_q[k] && src_tick && !as_chg) : wr_hit[k];
            assign commit_val[k] = async_clock_sel_q ? hold_q[k] : i_wdata;
            if (k < atc_pkg::RI_COUNT)
            begin : g_work
                // Working compare and control values.
                always_ff @(posedge i_clk or negedge i_rst_b)
                begin
                    if (!i_rst_b)
                        work_q[k] <= atc_pkg::RST_VAL;
                    else if (commit[k])
                        work_q[k] <= commit_val[k];
                end
            end
        end
    endgenerate

    // ************************************************
    // Counter and compare
    // ************************************************
    assign pwm     = (work_q[atc_pkg::RI_CTL_A][1:0] == atc_pkg::WGM_PHASE);
    assign match_a = cnt_tick && !blk_q && (count_value_q == work_q[atc_pkg::RI_CMP_A]);
    assign match_b = cnt_tick && !blk_q && (count_value_q == work_q[atc_pkg::RI_CMP_B]);
    assign wrap    = cnt_tick && (pwm ? (down_q && count_value_q == atc_pkg::CNT_BOTTOM)
                                      : (count_value_q == atc_pkg::CNT_MAX));

    // Count runs up, or up and down in phase-correct mode.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            count_value_q <= atc_pkg::RST_VAL;
            down_q        <= 1'b0;
        end
        else if (commit[atc_pkg::RI_COUNT])
            count_value_q <= commit_val[atc_pkg::RI_COUNT];
        else if (cnt_tick)
        begin
            if (pwm && !down_q && count_value_q == atc_pkg::CNT_MAX)
            begin
                down_q        <= 1'b1;
                count_value_q <= count_value_q - 1'b1;
            end
            else if (pwm && down_q && count_value_q == atc_pkg::CNT_BOTTOM)
            begin
                down_q        <= 1'b0;
                count_value_q <= count_value_q + 1'b1;
            end
            else if (pwm && down_q)
                count_value_q <= count_value_q - 1'b1;
            else
            begin
                down_q        <= 1'b0;
                count_value_q <= count_value_q + 1'b1;
            end
        end
    end

    // A count write masks the compare on the following timer tick.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            blk_q <= 1'b0;
        else if (commit[atc_pkg::RI_COUNT])
            blk_q <= 1'b1;
        else if (cnt_tick)
            blk_q <= 1'b0;
    end

    // Waveform pins toggle on each compare match.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_wave_out_a <= 1'b0;
            o_wave_out_b <= 1'b0;
        end
        else
        begin
            o_wave_out_a <= o_wave_out_a ^ match_a;
            o_wave_out_b <= o_wave_out_b ^ match_b;
        end
    end

    // ************************************************
    // Interrupt flags and requests
    // ************************************************
    // A clear by write or by vector wins over a set in the same cycle.
    assign flag_clr = (wr_flags ? i_wdata[2:0] : 3'h0) | i_irq_ack;
    assign flags_d  = (flags_q | {match_b, match_a, wrap}) & ~flag_clr;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            flags_q <= 3'h0;
        else
            flags_q <= flags_d;
    end

    // Enable register and gated requests.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            irq_en_q  <= atc_pkg::RST_VAL;
            o_irq_req <= 3'h0;
        end
        else
        begin
            if (wr_en)
                irq_en_q <= {5'h00, i_wdata[2:0]};
            o_irq_req <= flags_q & irq_en_q[2:0] & {3{i_global_ie}};
        end
    end

    // ************************************************
    // Clock source and prescaler control
    // ************************************************
    // Clock source bits; software sets the external bit first.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ext_clock_in_en_q  <= 1'b0;
            async_clock_sel_q  <= 1'b0;
            o_xtal_osc_en      <= 1'b1;
            o_ext_clock_buf_en <= 1'b0;
        end
        else
        begin
            if (wr_ast)
            begin
                ext_clock_in_en_q <= i_wdata[atc_pkg::B_EXT_CLK];
                async_clock_sel_q <= i_wdata[atc_pkg::B_AS_SEL];
            end
            o_xtal_osc_en      <= !ext_clock_in_en_q;
            o_ext_clock_buf_en <= ext_clock_in_en_q && async_clock_sel_q;
        end
    end

    // Sync mode keeps the reset bits; otherwise they clear themselves.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sync_hold_mode_q        <= 1'b0;
            async_prescale_reset_q  <= 1'b0;
            shared_prescale_reset_q <= 1'b0;
        end
        else if (wr_psc)
        begin
            sync_hold_mode_q        <= i_wdata[atc_pkg::B_TSM];
            async_prescale_reset_q  <= i_wdata[atc_pkg::B_PSR_ASY];
            shared_prescale_reset_q <= i_wdata[atc_pkg::B_PSR_SYN];
        end
        else if (!sync_hold_mode_q)
        begin
            shared_prescale_reset_q <= 1'b0;
            if (!async_clock_sel_q || src_tick)
                async_prescale_reset_q <= 1'b0;
        end
    end

    // Shared prescaler reset drives the other timers' prescaler.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_shared_prescale_rst <= 1'b0;
        else
            o_shared_prescale_rst <= shared_prescale_reset_q;
    end

    // ************************************************
    // Read data
    // ************************************************
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_rdata <= 8'h00;
        else if (i_rd)
        begin
            case (addr)
                atc_pkg::A_IRQ_FLAGS: o_rdata <= {5'h00, flags_q};
                atc_pkg::A_SYNC_PSC:  o_rdata <= {sync_hold_mode_q, 5'h00,
                                                  async_prescale_reset_q, shared_prescale_reset_q};
                atc_pkg::A_IRQ_EN:    o_rdata <= irq_en_q;
                atc_pkg::A_CTL_A:     o_rdata <= work_q[atc_pkg::RI_CTL_A];
                atc_pkg::A_CTL_B:     o_rdata <= {4'h0, work_q[atc_pkg::RI_CTL_B][3:0]};
                atc_pkg::A_COUNT:     o_rdata <= count_value_q;
                atc_pkg::A_CMP_A:     o_rdata <= work_q[atc_pkg::RI_CMP_A];
                atc_pkg::A_CMP_B:     o_rdata <= work_q[atc_pkg::RI_CMP_B];
                atc_pkg::A_ASYNC_ST:  o_rdata <= {1'b0, ext_clock_in_en_q, async_clock_sel_q, busy_q};
                default:              o_rdata <= 8'h00;
            endcase
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_match_a_flag: assert property (match_a && !flag_clr[1] |=> flags_q[1])
        else $error("compare A match did not set its flag");
    a_w1c_clear: assert property (wr_flags && i_wdata[2] |=> !flags_q[2])
        else $error("write one did not clear compare B flag");
    a_zero_keeps: assert property (wr_flags && !i_wdata[0] && i_irq_ack[0] == 1'b0 && flags_q[0]
                                   |=> flags_q[0])
        else $error("write zero changed the wrap flag");
    a_ack_clear: assert property (i_irq_ack[0] |=> !flags_q[0])
        else $error("vector did not clear the wrap flag");
    a_irq_gate: assert property (o_irq_req[1] |-> $past(flags_q[1] && irq_en_q[1] && i_global_ie))
        else $error("request without flag, enable and global bit");
    a_count_busy: assert property (async_clock_sel_q && wr_hit[4] && !as_chg |=> busy_q[4])
        else $error("async count write did not set busy");
    a_busy_waits: assert property (busy_q[3] && !src_tick && !as_chg && async_clock_sel_q
                                   |=> busy_q[3] && work_q[3] == $past(work_q[3]))
        else $error("compare A busy dropped before a timer tick");
    a_sync_hold: assert property (sync_hold_mode_q && shared_prescale_reset_q && !wr_psc
                                  |=> shared_prescale_reset_q)
        else $error("sync mode lost the shared reset bit");
    a_shared_clear: assert property (!sync_hold_mode_q && shared_prescale_reset_q && !wr_psc
                                     |=> !shared_prescale_reset_q ##1 !o_shared_prescale_rst)
        else $error("shared reset did not self clear");
    a_asy_wait: assert property (async_clock_sel_q && async_prescale_reset_q && !src_tick && !wr_psc
                                 |=> async_prescale_reset_q)
        else $error("async prescaler reset cleared early");
    a_count_block: assert property (blk_q && cnt_tick && !flags_q[1] |=> !flags_q[1])
        else $error("compare fired on tick after count write");
    a_xtal_en: assert property (ext_clock_in_en_q [*2] |-> !o_xtal_osc_en)
        else $error("crystal running with external clock set");

    c_match_a: cover property (match_a ##1 flags_q[1]);
    c_busy_done: cover property (busy_q[4] ##1 !busy_q[4]);
    c_tsm_release: cover property (sync_hold_mode_q ##1 !sync_hold_mode_q);
    c_pwm_wrap: cover property (pwm && wrap);
endmodule : atc_timer_regs
